// >>> include/spps_pkg.sv
package spps_pkg;
    // ********************************************
    // Register map
    // ********************************************
    localparam logic [7:0] SPPS_ADR_CTRL = 8'h00;
    localparam logic [7:0] SPPS_ADR_STAT = 8'h04;

    // Control fields
    localparam int SPPS_CTRL_GP_SEL = 0;
    localparam int SPPS_CTRL_GP_DIR = 1;
    localparam int SPPS_CTRL_GP_OUT = 2;
    localparam int SPPS_CTRL_W = 3;
    localparam logic [2:0] SPPS_CTRL_RST = 3'h0;

    // Status fields
    localparam int SPPS_STAT_SP2_STRAP = 0;
    localparam int SPPS_STAT_PCI_STRAP = 1;
    localparam int SPPS_STAT_EEPROM_AUTO_INIT_STRAP_STRAP = 2;
    localparam int SPPS_STAT_PORT_ON = 3;
    localparam int SPPS_STAT_PCI_MODE = 4;
    localparam int SPPS_STAT_GP_IN = 5;
    localparam int SPPS_STAT_CONFLICT = 6;
    localparam int SPPS_STAT_VALID = 7;

    // ********************************************
    // Synchroniser lanes
    // ********************************************
    localparam int SPPS_SYNC_W = 9;
    localparam int SPPS_LN_SP2 = 0;
    localparam int SPPS_LN_PCI = 1;
    localparam int SPPS_LN_EEPROM_AUTO_INIT_STRAP = 2;
    localparam int SPPS_LN_CLKS = 3;
    localparam int SPPS_LN_CLKR = 4;
    localparam int SPPS_LN_CLKX = 5;
    localparam int SPPS_LN_DR = 6;
    localparam int SPPS_LN_FSR = 7;
    localparam int SPPS_LN_FSX = 8;

    // Level fed to an unselected function's input
    localparam logic SPPS_IDLE_LVL = 1'b0;
endpackage

// >>> rtl/spps_sync.sv
`timescale 1ns/10ps
`default_nettype none
module spps_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    // ********************************************
    // Two-stage synchroniser
    // ********************************************
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } spps_sync_s;

    spps_sync_s st_q;
    spps_sync_s st_d;

    always_comb begin
        st_d.meta = async_i;
        // First stage feeds only the second stage
        st_d.stab = st_q.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stab;
endmodule // spps_sync
`default_nettype wire

// >>> rtl/spps_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RL1 - Port and PCI-EEPROM roles follow the port enable and PCI enable straps.
// RL2 - Receive clock pin tied off when PCI enable is 1 and port enable 0.
// RL3 - Both frame-sync pins tied off under that same disabled combination.
// RL4 - Clock-source pin is input by default; programmable as tristate general I/O 8.
// RL5 - Transmit clock pin is port clock, or driven EEPROM clock in PCI mode.
// RL6 - Receive data pin feeds port, or EEPROM data-in in PCI mode.
// RL7 - Transmit data pin carries port data, or EEPROM data-out in PCI mode.
// RL8 - Board keeps auto-init strap low while PCI is disabled.
// RL9 - Unselected function inputs see a fixed idle level.
module spps_pin_mux
    import spps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Straps
    input wire logic serial_port2_enable_strap_i,
    input wire logic pci_enable_strap_i,
    input wire logic eeprom_auto_init_strap_i,
    // Pins
    input wire logic port2_ext_clock_source_in_i,
    output logic port2_ext_clock_source_out_o,
    output logic port2_ext_clock_source_oe_o,
    input wire logic port2_receive_clock_in_i,
    output logic port2_receive_clock_out_o,
    output logic port2_receive_clock_oe_o,
    input wire logic port2_transmit_clock_in_i,
    output logic port2_transmit_clock_out_o,
    output logic port2_transmit_clock_oe_o,
    input wire logic port2_receive_data_i,
    output logic port2_transmit_data_out_o,
    output logic port2_transmit_data_oe_o,
    input wire logic port2_receive_frame_sync_in_i,
    output logic port2_receive_frame_sync_out_o,
    output logic port2_receive_frame_sync_oe_o,
    input wire logic port2_transmit_frame_sync_in_i,
    output logic port2_transmit_frame_sync_out_o,
    output logic port2_transmit_frame_sync_oe_o,
    // Serial port core side
    output logic sp_clks_o,
    output logic sp_clkr_o,
    input wire logic sp_clkr_out_i,
    input wire logic sp_clkr_oe_i,
    output logic sp_clkx_o,
    input wire logic sp_clkx_out_i,
    input wire logic sp_clkx_oe_i,
    output logic sp_dr_o,
    input wire logic sp_dx_i,
    input wire logic sp_dx_oe_i,
    output logic sp_fsr_o,
    input wire logic sp_fsr_out_i,
    input wire logic sp_fsr_oe_i,
    output logic sp_fsx_o,
    input wire logic sp_fsx_out_i,
    input wire logic sp_fsx_oe_i,
    // EEPROM interface side
    input wire logic eeprom_serial_clock_i,
    input wire logic eeprom_serial_data_out_i,
    output logic eeprom_serial_data_in_o,
    // Mode
    output logic port2_enabled_o,
    output logic pci_mode_o
);
    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        logic strap_valid;
        logic [1:0] fill;
        logic sp2_en;
        logic pci_en;
        logic eeprom_auto_init_strap;
        logic [SPPS_CTRL_W-1:0] ctrl;
        logic ack;
        logic [31:0] rdat;
        logic clks_out, clks_oe;
        logic clkr_out, clkr_oe;
        logic clkx_out, clkx_oe;
        logic dx_out, dx_oe;
        logic fsr_out, fsr_oe;
        logic fsx_out, fsx_oe;
        logic c_clks, c_clkr, c_clkx, c_dr, c_fsr, c_fsx, e_din;
    } spps_state_s;

    spps_state_s st_q;
    spps_state_s st_d;
    logic [SPPS_SYNC_W-1:0] raw;
    logic [SPPS_SYNC_W-1:0] syn;
    logic port_off;
    logic gp_sel;
    logic req;

    function automatic logic [31:0] status_word(input spps_state_s s, input logic gp_in);
        logic [31:0] w;
        w = 32'h0;
        w[SPPS_STAT_SP2_STRAP] = s.sp2_en;
        w[SPPS_STAT_PCI_STRAP] = s.pci_en;
        w[SPPS_STAT_EEPROM_AUTO_INIT_STRAP_STRAP] = s.eeprom_auto_init_strap;
        w[SPPS_STAT_PORT_ON] = !(s.pci_en && !s.sp2_en);
        w[SPPS_STAT_PCI_MODE] = s.pci_en && !s.sp2_en;
        w[SPPS_STAT_GP_IN] = gp_in;
        w[SPPS_STAT_CONFLICT] = s.eeprom_auto_init_strap && !s.pci_en;
        w[SPPS_STAT_VALID] = s.strap_valid;
        return w;
    endfunction

    // ********************************************
    // Input synchronisers
    // ********************************************
    always_comb begin
        raw = '0;
        raw[SPPS_LN_SP2] = serial_port2_enable_strap_i;
        raw[SPPS_LN_PCI] = pci_enable_strap_i;
        raw[SPPS_LN_EEPROM_AUTO_INIT_STRAP] = eeprom_auto_init_strap_i;
        raw[SPPS_LN_CLKS] = port2_ext_clock_source_in_i;
        raw[SPPS_LN_CLKR] = port2_receive_clock_in_i;
        raw[SPPS_LN_CLKX] = port2_transmit_clock_in_i;
        raw[SPPS_LN_DR] = port2_receive_data_i;
        raw[SPPS_LN_FSR] = port2_receive_frame_sync_in_i;
        raw[SPPS_LN_FSX] = port2_transmit_frame_sync_in_i;
    end

    spps_sync #(.W(SPPS_SYNC_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(raw),
        .sync_o(syn)
    );

    // ********************************************
    // Next state
    // ********************************************
    // Disabled port means the pins belong to the EEPROM interface
    assign port_off = st_q.strap_valid && st_q.pci_en && !st_q.sp2_en; // [RL1]
    assign gp_sel = st_q.ctrl[SPPS_CTRL_GP_SEL];
    assign req = wb_cyc_i && wb_stb_i;

    always_comb begin
        st_d = st_q;
        // Synchroniser is cleared by reset; wait until both stages hold pin levels
        st_d.fill = {st_q.fill[0], 1'b1};
        if (!st_q.strap_valid && st_q.fill[1]) begin
            st_d.strap_valid = 1'b1;
            st_d.sp2_en = syn[SPPS_LN_SP2]; // [RL1]
            st_d.pci_en = syn[SPPS_LN_PCI]; // [RL1]
            st_d.eeprom_auto_init_strap = syn[SPPS_LN_EEPROM_AUTO_INIT_STRAP];
        end
        // Bus: ack one cycle after request, write on the acked edge
        st_d.ack = req && !st_q.ack;
        if (req && !st_q.ack) begin
            if (wb_adr_i == SPPS_ADR_CTRL) begin
                st_d.rdat = {29'h0, st_q.ctrl};
            end else if (wb_adr_i == SPPS_ADR_STAT) begin
                st_d.rdat = status_word(st_q, syn[SPPS_LN_CLKS]);
            end else begin
                st_d.rdat = 32'h0;
            end
        end
        if (req && st_q.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == SPPS_ADR_CTRL) begin
            st_d.ctrl = wb_dat_i[SPPS_CTRL_W-1:0];
        end

        // Clock source pin: input only unless general I/O 8 chosen
        st_d.clks_oe = gp_sel && st_q.ctrl[SPPS_CTRL_GP_DIR]; // [RL4]
        st_d.clks_out = gp_sel && st_q.ctrl[SPPS_CTRL_GP_OUT]; // [RL4]
        st_d.c_clks = gp_sel ? SPPS_IDLE_LVL : syn[SPPS_LN_CLKS]; // [RL4] [RL9]

        // Tie-offs: pin released, core input held idle
        st_d.clkr_oe = !port_off && sp_clkr_oe_i; // [RL2]
        st_d.clkr_out = !port_off && sp_clkr_out_i; // [RL2]
        st_d.c_clkr = port_off ? SPPS_IDLE_LVL : syn[SPPS_LN_CLKR]; // [RL2] [RL9]
        st_d.fsr_oe = !port_off && sp_fsr_oe_i; // [RL3]
        st_d.fsr_out = !port_off && sp_fsr_out_i; // [RL3]
        st_d.c_fsr = port_off ? SPPS_IDLE_LVL : syn[SPPS_LN_FSR]; // [RL3] [RL9]
        st_d.fsx_oe = !port_off && sp_fsx_oe_i; // [RL3]
        st_d.fsx_out = !port_off && sp_fsx_out_i; // [RL3]
        st_d.c_fsx = port_off ? SPPS_IDLE_LVL : syn[SPPS_LN_FSX]; // [RL3] [RL9]

        if (port_off) begin
            // EEPROM clock always driven; PROM owns data-in line
            st_d.clkx_oe = 1'b1; // [RL5]
            st_d.clkx_out = eeprom_serial_clock_i; // [RL5]
            st_d.c_clkx = SPPS_IDLE_LVL; // [RL9]
            st_d.dx_oe = 1'b1; // [RL7]
            st_d.dx_out = eeprom_serial_data_out_i; // [RL7]
            st_d.c_dr = SPPS_IDLE_LVL; // [RL9]
            st_d.e_din = syn[SPPS_LN_DR]; // [RL6]
        end else begin
            st_d.clkx_oe = sp_clkx_oe_i; // [RL5]
            st_d.clkx_out = sp_clkx_out_i; // [RL5]
            st_d.c_clkx = syn[SPPS_LN_CLKX]; // [RL5]
            st_d.dx_oe = sp_dx_oe_i; // [RL7]
            st_d.dx_out = sp_dx_i; // [RL7]
            st_d.c_dr = syn[SPPS_LN_DR]; // [RL6]
            st_d.e_din = SPPS_IDLE_LVL; // [RL9]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.ctrl <= SPPS_CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign wb_ack_o = st_q.ack;
    assign wb_dat_o = st_q.rdat;
    assign port2_ext_clock_source_out_o = st_q.clks_out;
    assign port2_ext_clock_source_oe_o = st_q.clks_oe;
    assign port2_receive_clock_out_o = st_q.clkr_out;
    assign port2_receive_clock_oe_o = st_q.clkr_oe;
    assign port2_transmit_clock_out_o = st_q.clkx_out;
    assign port2_transmit_clock_oe_o = st_q.clkx_oe;
    assign port2_transmit_data_out_o = st_q.dx_out;
    assign port2_transmit_data_oe_o = st_q.dx_oe;
    assign port2_receive_frame_sync_out_o = st_q.fsr_out;
    assign port2_receive_frame_sync_oe_o = st_q.fsr_oe;
    assign port2_transmit_frame_sync_out_o = st_q.fsx_out;
    assign port2_transmit_frame_sync_oe_o = st_q.fsx_oe;
    assign sp_clks_o = st_q.c_clks;
    assign sp_clkr_o = st_q.c_clkr;
    assign sp_clkx_o = st_q.c_clkx;
    assign sp_dr_o = st_q.c_dr;
    assign sp_fsr_o = st_q.c_fsr;
    assign sp_fsx_o = st_q.c_fsx;
    assign eeprom_serial_data_in_o = st_q.e_din;
    assign port2_enabled_o = st_q.strap_valid && !port_off;
    assign pci_mode_o = port_off;

    // ********************************************
    // Assertions
    // ********************************************
    sequence s_off_held;
        port_off ##1 port_off;
    endsequence

    sequence s_gp_out_held;
        gp_sel && st_q.ctrl[SPPS_CTRL_GP_DIR] ##1 gp_sel && st_q.ctrl[SPPS_CTRL_GP_DIR];
    endsequence

    AST_MODE_FROM_STRAPS: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
        st_q.strap_valid |-> (pci_mode_o == (st_q.pci_en && !st_q.sp2_en))
            && (port2_enabled_o == !pci_mode_o))
        else $error("mode does not follow straps");

    AST_STRAPS_FROZEN: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
        st_q.strap_valid |=> $stable({st_q.sp2_en, st_q.pci_en, st_q.eeprom_auto_init_strap}))
        else $error("straps changed after capture");

    AST_CAPTURE_AFTER_FILL: assert property (@(posedge clk_i) disable iff (rst_i) // [RL1]
        st_q.fill[1] |=> st_q.strap_valid)
        else $error("straps not captured after synchroniser fill");

    AST_CLKR_TIED: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
        s_off_held |-> !port2_receive_clock_oe_o && !sp_clkr_o)
        else $error("receive clock not tied off");

    AST_FS_TIED: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
        s_off_held |-> !port2_receive_frame_sync_oe_o && !port2_transmit_frame_sync_oe_o
            && !sp_fsr_o && !sp_fsx_o)
        else $error("frame sync not tied off");

    AST_GPIO_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
        s_gp_out_held |-> port2_ext_clock_source_oe_o
            && port2_ext_clock_source_out_o == $past(st_q.ctrl[SPPS_CTRL_GP_OUT]))
        else $error("general I/O 8 not driven");

    AST_CLKS_INPUT: assert property (@(posedge clk_i) disable iff (rst_i) // [RL4]
        !gp_sel ##1 !gp_sel |-> !port2_ext_clock_source_oe_o)
        else $error("clock source pin driven while input");

    AST_EEPROM_SERIAL_CLOCK: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
        s_off_held |-> port2_transmit_clock_oe_o
            && port2_transmit_clock_out_o == $past(eeprom_serial_clock_i))
        else $error("EEPROM clock not on transmit clock pin");

    AST_DIN_PATH: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
        s_off_held |-> eeprom_serial_data_in_o == $past(syn[SPPS_LN_DR]) && !sp_dr_o)
        else $error("EEPROM data in not routed");

    AST_DOUT_PATH: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
        !port_off ##1 !port_off |-> port2_transmit_data_oe_o == $past(sp_dx_oe_i)
            && port2_transmit_data_out_o == $past(sp_dx_i) && !eeprom_serial_data_in_o)
        else $error("port transmit data not routed");

    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
endmodule // spps_pin_mux
`default_nettype wire

// >>> verification/spps_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Pin peers and serial PROM
// ****************************************
module spps_peer (
    input wire logic [4:0] dev_out_i,
    input wire logic [4:0] dev_oe_i,
    input wire logic [4:0] drv_i,
    input wire logic [4:0] lvl_i,
    input wire logic prom_sel_i,
    input wire logic dx_out_i,
    input wire logic dx_oe_i,
    input wire logic dr_lvl_i,
    output logic [4:0] pin_o,
    output logic dr_o
);
    logic prom_q = 1'b1;
    logic dx;
    // Undriven pins fall to their pull-downs
    always_comb begin
        for (int k = 0; k < 5; k++) begin
            pin_o[k] = dev_oe_i[k] ? dev_out_i[k] : (drv_i[k] & lvl_i[k]);
        end
    end
    assign dx = dx_oe_i ? dx_out_i : 1'b1;
    // PROM echoes the inverse, so a stuck line cannot pass
    always @(posedge pin_o[2]) begin
        prom_q <= ~dx;
    end
    assign dr_o = prom_sel_i ? prom_q : dr_lvl_i;
endmodule // spps_peer
`default_nettype wire

// >>> verification/spps_pin_mux_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spps_pin_mux_bench;
    import spps_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic serial_port2_enable_strap_i, pci_enable_strap_i, eeprom_auto_init_strap_i;
    logic port2_ext_clock_source_in_i, port2_ext_clock_source_out_o, port2_ext_clock_source_oe_o;
    logic port2_receive_clock_in_i, port2_receive_clock_out_o, port2_receive_clock_oe_o;
    logic port2_transmit_clock_in_i, port2_transmit_clock_out_o, port2_transmit_clock_oe_o;
    logic port2_receive_data_i, port2_transmit_data_out_o, port2_transmit_data_oe_o;
    logic port2_receive_frame_sync_in_i, port2_receive_frame_sync_out_o;
    logic port2_receive_frame_sync_oe_o, port2_transmit_frame_sync_in_i;
    logic port2_transmit_frame_sync_out_o, port2_transmit_frame_sync_oe_o;
    logic sp_clks_o, sp_clkr_o, sp_clkr_out_i, sp_clkr_oe_i, sp_clkx_o, sp_clkx_out_i;
    logic sp_clkx_oe_i, sp_dr_o, sp_dx_i, sp_dx_oe_i, sp_fsr_o, sp_fsr_out_i, sp_fsr_oe_i;
    logic sp_fsx_o, sp_fsx_out_i, sp_fsx_oe_i, eeprom_serial_clock_i, eeprom_serial_data_out_i;
    logic eeprom_serial_data_in_o, port2_enabled_o, pci_mode_o, dr_lvl;
    logic [4:0] drv, lvl, pin;
    int fails = 0;
    int checked = 0;
    spps_pin_mux spps_pin_mux_i (.*);
    spps_peer spps_peer_i (
        .dev_out_i({port2_transmit_frame_sync_out_o, port2_receive_frame_sync_out_o,
            port2_transmit_clock_out_o, port2_receive_clock_out_o, port2_ext_clock_source_out_o}),
        .dev_oe_i({port2_transmit_frame_sync_oe_o, port2_receive_frame_sync_oe_o,
            port2_transmit_clock_oe_o, port2_receive_clock_oe_o, port2_ext_clock_source_oe_o}),
        .drv_i(drv),
        .lvl_i(lvl),
        .prom_sel_i(pci_enable_strap_i & ~serial_port2_enable_strap_i),
        .dx_out_i(port2_transmit_data_out_o),
        .dx_oe_i(port2_transmit_data_oe_o),
        .dr_lvl_i(dr_lvl),
        .pin_o(pin),
        .dr_o(port2_receive_data_i)
    );
    assign {port2_transmit_frame_sync_in_i, port2_receive_frame_sync_in_i,
        port2_transmit_clock_in_i, port2_receive_clock_in_i, port2_ext_clock_source_in_i} = pin;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Classic cycle; the bound only guards against a dead slave
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic do_rst(input logic s, input logic p, input logic e);
        @(posedge clk_i);
        rst_i <= 1'b1;
        {serial_port2_enable_strap_i, pci_enable_strap_i} <= {s, p};
        eeprom_auto_init_strap_i <= e & p;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        #(50 * 3000);
        fails++;
        end_sim();
    end
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {serial_port2_enable_strap_i, pci_enable_strap_i, eeprom_auto_init_strap_i} = 3'h4;
        {sp_clkr_out_i, sp_fsr_out_i, sp_fsx_out_i, eeprom_serial_clock_i} = 4'h0;
        {eeprom_serial_data_out_i, sp_fsx_oe_i} = 2'h0;
        {sp_dx_i, sp_dx_oe_i, sp_clkx_out_i, sp_clkx_oe_i, sp_clkr_oe_i, sp_fsr_oe_i} = 6'h3c;
        {drv, lvl, dr_lvl} = {5'h1b, 5'h1b, 1'b1};
        do_rst(1'b1, 1'b0, 1'b0);
        step(5);
        chk({port2_transmit_data_oe_o, port2_transmit_data_out_o}, 2'h3);
        chk({port2_transmit_clock_oe_o, port2_transmit_clock_out_o}, 2'h3);
        chk(sp_clkx_o, 1'b1);
        chk({sp_dr_o, eeprom_serial_data_in_o}, 2'h2);
        chk({sp_clks_o, sp_clkr_o, sp_fsr_o, sp_fsx_o}, 4'hf);
        chk({pci_mode_o, port2_enabled_o}, 2'h1);
        wb(1'b0, SPPS_ADR_STAT, 32'h0, 4'hf);
        chk(q, 32'h0000_00a9);
        wb(1'b1, SPPS_ADR_CTRL, 32'h0000_0007, 4'hf);
        step(3);
        chk({port2_ext_clock_source_oe_o, port2_ext_clock_source_out_o, sp_clks_o}, 3'h6);
        wb(1'b1, SPPS_ADR_CTRL, 32'h0, 4'h0);
        wb(1'b0, SPPS_ADR_CTRL, 32'h0, 4'hf);
        chk(q, 32'h0000_0007);
        wb(1'b0, 8'h08, 32'h0, 4'hf);
        chk(q, 32'h0);
        wb(1'b1, SPPS_ADR_CTRL, 32'h0000_0001, 4'hf);
        step(1);
        chk(port2_ext_clock_source_oe_o, 1'b0);
        {sp_fsx_oe_i, sp_dx_oe_i, sp_dx_i} <= 3'h4;
        do_rst(1'b0, 1'b1, 1'b1);
        step(5);
        chk({port2_receive_clock_oe_o, sp_clkr_o}, 2'h0);
        chk({port2_receive_frame_sync_oe_o, port2_transmit_frame_sync_oe_o}, 2'h0);
        chk({sp_fsr_o, sp_fsx_o}, 2'h0);
        chk({pci_mode_o, port2_enabled_o}, 2'h2);
        wb(1'b0, SPPS_ADR_STAT, 32'h0, 4'hf);
        chk(q, 32'h0000_00b6);
        @(posedge clk_i);
        eeprom_serial_data_out_i <= 1'b1;
        step(1);
        chk({port2_transmit_data_oe_o, port2_transmit_data_out_o}, 2'h3);
        chk({port2_transmit_clock_oe_o, port2_transmit_clock_out_o}, 2'h2);
        chk(sp_clkx_o, 1'b0);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            {eeprom_serial_clock_i, eeprom_serial_data_out_i} <= {1'b0, k == 0};
            @(posedge clk_i);
            eeprom_serial_clock_i <= 1'b1;
            step(4);
            chk(port2_transmit_clock_out_o, 1'b1);
            chk({eeprom_serial_data_in_o, sp_dr_o}, {k[0], 1'b0});
        end
        {sp_fsr_oe_i, sp_fsr_out_i} <= 2'h3;
        do_rst(1'b1, 1'b1, 1'b0);
        step(5);
        chk({pci_mode_o, port2_enabled_o, port2_receive_frame_sync_oe_o,
            port2_receive_frame_sync_out_o}, 4'h7);
        end_sim();
    end
endmodule // spps_pin_mux_bench
`default_nettype wire
